// ### pkg/mdf_pkg.sv
// package for the modem deviation / afc / filter configuration bank
// assumes an axi4-lite master on the same clock drives the register bus
package mdf_pkg;
    // register word indices; byte address is the index times four
    localparam logic [7:0] TX_DEV_IDX = 8'h0E;
    localparam logic [7:0] AFC_IDX = 8'h0F;
    localparam logic [7:0] FILT_IDX = 8'h10;
    localparam logic [9:0] TX_DEV_ADDR = {TX_DEV_IDX, 2'b00};
    localparam logic [9:0] AFC_ADDR = {AFC_IDX, 2'b00};
    localparam logic [9:0] FILT_ADDR = {FILT_IDX, 2'b00};
    // reset values
    localparam logic [7:0] TX_DEV_RST = 8'hE8;
    localparam logic [7:0] AFC_RST = 8'h9C;
    localparam logic [7:0] FILT_RST = 8'h00;
    // field positions
    localparam int SHAPING_BIT = 7;
    localparam int TX_EXP_LSB = 4;
    localparam int SETTLE_LSB = 6;
    localparam int RX_EXP_LSB = 4;
    localparam int BYPASS_BIT = 7;
    localparam int SHIFT_LSB = 5;
    // writable bits of the filter register (bits 4:3 reserved)
    localparam logic [7:0] FILT_WMASK = 8'hE7;
    // deviation exponent offsets per band
    localparam logic [5:0] TX_EXP_OFS_LOW = 6'h10;
    localparam logic [5:0] TX_EXP_OFS_HIGH = 6'h0F;
    localparam logic [5:0] RX_EXP_OFS = 6'h03;
    // highest decimation code selects divisor 8
    localparam logic [2:0] DEC_CODE_MAX = 3'h7;
    localparam logic [3:0] DECIM_DIV_MAX = 4'h8;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {AFC_OFF, AFC_AVG1, AFC_AVG2, AFC_AVG4} mdf_settle_e;

    // decoded modem settings handed to the datapath
    typedef struct packed {
        logic gauss_shaping;
        logic on_off_keying;
        logic [2:0] tx_dev_exponent;
        logic [3:0] tx_dev_mantissa;
        logic [5:0] tx_dev_shift;
        logic afc_enable;
        logic [2:0] afc_avg_pairs;
        logic [1:0] rx_dev_exponent;
        logic [3:0] rx_dev_mantissa;
        logic filter_bypass;
        logic [1:0] decimator_input_shift;
        logic [3:0] decim_divisor;
    } mdf_cfg_s;
endpackage

// ### hw/mdf_decode.sv
// decodes the three raw configuration bytes into modem settings
// assumes inputs are registered values from the bank on the same clock
module mdf_decode (
    // raw register contents
    input wire logic [7:0] tx_dev_in,
    input wire logic [7:0] afc_in,
    input wire logic [7:0] filt_in,
    // band select: 1 = upper band
    input wire logic upper_band_in,
    // decoded settings
    output mdf_pkg::mdf_cfg_s cfg_out
);
    // divisor is code plus one, except the top code gives eight
    function automatic logic [3:0] dec_divisor(input logic [2:0] code);
        if (code == mdf_pkg::DEC_CODE_MAX) begin
            return mdf_pkg::DECIM_DIV_MAX;
        end
        return {1'b0, code} + 4'h1;
    endfunction

    // combinational field decode
    always_comb begin
        cfg_out.gauss_shaping = tx_dev_in[mdf_pkg::SHAPING_BIT];
        cfg_out.tx_dev_exponent = tx_dev_in[mdf_pkg::TX_EXP_LSB +: 3];
        cfg_out.tx_dev_mantissa = tx_dev_in[3:0];
        cfg_out.on_off_keying = (tx_dev_in[3:0] == 4'h0);
        // signed power-of-two shift: exponent minus band offset, two's complement
        if (upper_band_in) begin
            cfg_out.tx_dev_shift = {3'h0, tx_dev_in[6:4]} - mdf_pkg::TX_EXP_OFS_HIGH;
        end else begin
            cfg_out.tx_dev_shift = {3'h0, tx_dev_in[6:4]} - mdf_pkg::TX_EXP_OFS_LOW;
        end
        cfg_out.afc_enable = (afc_in[mdf_pkg::SETTLE_LSB +: 2] != 2'h0);
        unique case (mdf_pkg::mdf_settle_e'(afc_in[mdf_pkg::SETTLE_LSB +: 2]))
            mdf_pkg::AFC_OFF: cfg_out.afc_avg_pairs = 3'h0;
            mdf_pkg::AFC_AVG1: cfg_out.afc_avg_pairs = 3'h1;
            mdf_pkg::AFC_AVG2: cfg_out.afc_avg_pairs = 3'h2;
            mdf_pkg::AFC_AVG4: cfg_out.afc_avg_pairs = 3'h4;
        endcase
        cfg_out.rx_dev_exponent = afc_in[mdf_pkg::RX_EXP_LSB +: 2];
        cfg_out.rx_dev_mantissa = afc_in[3:0];
        cfg_out.filter_bypass = filt_in[mdf_pkg::BYPASS_BIT];
        cfg_out.decimator_input_shift = filt_in[mdf_pkg::SHIFT_LSB +: 2];
        cfg_out.decim_divisor = dec_divisor(filt_in[2:0]);
    end
endmodule // mdf_decode

// ### hw/mdf_bank.sv
// register bank: transmit deviation, afc / receive deviation, channel filter
// assumes an axi4-lite master on clk_in; modem datapath consumes cfg_out
// Function
// - bit 7 enables gaussian transmit shaping
// - tx exponent bits 6:4, mantissa 3:0
// - lower band: fref*m*2^(e-16)
// - upper band: fref*m*2^(e-15)
// - mantissa zero selects on-off keying
// - settling zero disables afc, zero average
// - codes 1,2,3 average 1,2,4 pairs
// - rx exponent 5:4, mantissa 3:0
// - bit 7 bypasses analog anti-alias filter
// - bits 6:5 give decimator input shift
// - divisor code+1, top code gives 8
// - bandwidth 307.2 kHz over divisor
//
// The AXI4-Lite register port was left to the implementer.
module mdf_bank (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // band select pin from outside the clock domain
    input wire logic upper_band_in,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // decoded settings and channel bandwidth (in units of 0.1 kHz)
    output mdf_pkg::mdf_cfg_s cfg_out,
    output logic [11:0] chan_bw_out
);
    // channel filter bandwidth at divisor one, in 0.1 kHz
    localparam logic [11:0] BW_BASE = 12'hC00;

    // registers
    logic [7:0] tx_dev_q, tx_dev_d; // tx deviation setting
    logic [7:0] afc_q, afc_d; // freq correction and rx deviation
    logic [7:0] filt_q, filt_d; // channel filter setting
    // write channel capture
    logic aw_have_q, aw_have_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic w_have_q, w_have_d;
    logic [7:0] w_byte_q, w_byte_d;
    logic w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    // read channel
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    // band pin synchroniser
    logic band_m_q, band_s_q;
    // decoded settings
    mdf_pkg::mdf_cfg_s cfg_c;
    mdf_pkg::mdf_cfg_s cfg_q;
    logic [11:0] bw_q, bw_d;
    logic do_write;
    // registered ready flags, one per request channel
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic arready_q, arready_d;

    // address lookup returning the register index, or all ones if unmapped
    function automatic logic [1:0] reg_sel(input logic [11:0] addr);
        if (addr[11:10] != 2'h0) begin
            return 2'h3;
        end
        unique case (addr[9:0])
            mdf_pkg::TX_DEV_ADDR: return 2'h0;
            mdf_pkg::AFC_ADDR: return 2'h1;
            mdf_pkg::FILT_ADDR: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction

    // field decode
    mdf_decode u_decode (
        .tx_dev_in(tx_dev_q),
        .afc_in(afc_q),
        .filt_in(filt_q),
        .upper_band_in(band_s_q),
        .cfg_out(cfg_c)
    );

    // write path next state
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_byte_d = w_byte_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        tx_dev_d = tx_dev_q;
        afc_d = afc_q;
        filt_d = filt_q;
        // address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            w_byte_d = s_axi_wdata[7:0];
            w_strb_d = s_axi_wstrb[0];
        end
        do_write = aw_have_q && w_have_q && !bvalid_q;
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mdf_pkg::RESP_OKAY;
            // only lane 0 carries register bits
            unique case (reg_sel(aw_addr_q))
                2'h0: if (w_strb_q) tx_dev_d = w_byte_q;
                2'h1: if (w_strb_q) afc_d = w_byte_q;
                2'h2: if (w_strb_q) filt_d = w_byte_q & mdf_pkg::FILT_WMASK;
                default: bresp_d = mdf_pkg::RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // each channel accepts again only once it holds nothing and no response waits
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    // read path next state
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = mdf_pkg::RESP_OKAY;
            unique case (reg_sel(s_axi_araddr))
                2'h0: rdata_d = {24'h0, tx_dev_q};
                2'h1: rdata_d = {24'h0, afc_q};
                2'h2: rdata_d = {24'h0, filt_q};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = mdf_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // one read at a time: refuse while read data waits
        arready_d = !rvalid_d;
    end

    // bandwidth: base over divisor, no divider needed for eight codes
    always_comb begin
        unique case (cfg_c.decim_divisor)
            4'h1: bw_d = BW_BASE;
            4'h2: bw_d = 12'h600;
            4'h3: bw_d = 12'h400;
            4'h4: bw_d = 12'h300;
            4'h5: bw_d = 12'h266;
            4'h6: bw_d = 12'h200;
            4'h7: bw_d = 12'h1B6;
            default: bw_d = 12'h180;
        endcase
    end

    // ready flags come from flops; low in reset and one clock after it
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_arready = arready_q;

    // registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_dev_q <= mdf_pkg::TX_DEV_RST;
            afc_q <= mdf_pkg::AFC_RST;
            filt_q <= mdf_pkg::FILT_RST;
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_have_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_strb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= mdf_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= mdf_pkg::RESP_OKAY;
            band_m_q <= 1'b0;
            band_s_q <= 1'b0;
            cfg_q <= '0;
            bw_q <= BW_BASE;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            tx_dev_q <= tx_dev_d;
            afc_q <= afc_d;
            filt_q <= filt_d;
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_byte_q <= w_byte_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            band_m_q <= upper_band_in;
            band_s_q <= band_m_q;
            cfg_q <= cfg_c;
            bw_q <= bw_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end

    // outputs straight from flops
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign cfg_out = cfg_q;
    assign chan_bw_out = bw_q;

    // checks: decoded outputs lag the registers by one clock, skipped on the edge after reset
    chk_onoff_select: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> (cfg_out.on_off_keying == ($past(tx_dev_q[3:0]) == 4'h0)))
        else $error("on-off keying does not follow zero mantissa");
    chk_shaping_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> (cfg_out.gauss_shaping == $past(tx_dev_q[7])))
        else $error("shaping output does not follow bit 7");
    chk_afc_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(afc_q[7:6]) == 2'h0 |-> (!cfg_out.afc_enable && cfg_out.afc_avg_pairs == 3'h0))
        else $error("afc not off for settling zero");
    chk_afc_slow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(afc_q[7:6]) == 2'h3 |-> (cfg_out.afc_avg_pairs == 3'h4))
        else $error("slowest settling must average four pairs");
    chk_rx_fields: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> ({cfg_out.rx_dev_exponent, cfg_out.rx_dev_mantissa} == $past(afc_q[5:0])))
        else $error("rx deviation fields misplaced");
    chk_div_top: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(filt_q[2:0]) == 3'h7 |-> (cfg_out.decim_divisor == 4'h8))
        else $error("top decimation code must divide by eight");
    chk_div_plain: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(filt_q[2:0]) != 3'h7
        |-> (cfg_out.decim_divisor == {1'b0, $past(filt_q[2:0])} + 4'h1))
        else $error("decimation divisor is not code plus one");
    chk_bw_full: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(filt_q[2:0]) == 3'h0 |-> (chan_bw_out == 12'hC00))
        else $error("divisor one must give full bandwidth");
    chk_bypass_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> (cfg_out.filter_bypass == $past(filt_q[7])))
        else $error("filter bypass does not follow bit 7");
    chk_decimator_input_shift: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> (cfg_out.decimator_input_shift == $past(filt_q[6:5])))
        else $error("decimator input shift misplaced");
    chk_filt_resv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        filt_q[4:3] == 2'h0)
        else $error("reserved filter bits were stored");
    chk_wr_store: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (do_write && reg_sel(aw_addr_q) == 2'h1 && w_strb_q) |=> (afc_q == $past(w_byte_q) && s_axi_bvalid))
        else $error("afc register write not stored with response");
    chk_tx_exp: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> (cfg_out.tx_dev_exponent == $past(tx_dev_q[6:4])))
        else $error("tx exponent field misplaced");
    chk_shift_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && !$past(band_s_q) |-> (cfg_out.tx_dev_shift == 6'($past(tx_dev_q[6:4]) - 6'h10)))
        else $error("lower band shift wrong");
    chk_shift_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(band_s_q) |-> (cfg_out.tx_dev_shift == 6'($past(tx_dev_q[6:4]) - 6'h0F)))
        else $error("upper band shift wrong");
    chk_rd_answer: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    cov_write: cover property (@(posedge clk_in) disable iff (sys_rst_in) do_write);
    cov_onoff: cover property (@(posedge clk_in) disable iff (sys_rst_in) cfg_out.on_off_keying);
    cov_upper_band: cover property (@(posedge clk_in) disable iff (sys_rst_in) band_s_q);
    cov_div8: cover property (@(posedge clk_in) disable iff (sys_rst_in) cfg_out.decim_divisor == 4'h8);
    cov_rderr: cover property (@(posedge clk_in) disable iff (sys_rst_in) s_axi_rvalid && s_axi_rresp != 2'h0);
endmodule // mdf_bank

// ### verif/mdf_bank_tb.sv
// self-checking bench for the modem deviation / afc / filter register bank
// assumes mdf_pkg is compiled first; the bench acts as the axi4-lite master
module mdf_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // clock, reset and band pin
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic upper_band_in = 1'b0;
    // axi4-lite master signals
    logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_bvalid, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    // decoded outputs
    mdf_pkg::mdf_cfg_s cfg_out;
    logic [11:0] chan_bw_out;
    int errors = 0;
    int check_count = 0;

    // 100 mhz clock
    always #5 clk_in = ~clk_in;

    mdf_bank u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .upper_band_in(upper_band_in),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .cfg_out(cfg_out), .chan_bw_out(chan_bw_out));

    // compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic complete_run();
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hold reset for four edges, release after an edge
    task automatic do_reset();
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
    endtask

    // one write; readies sampled mid-cycle so they match the next edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit;
        int n;
        n = 0;
        b_hit = 1'b0;
        r = 2'h3;
        @(posedge clk_in);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        while (!b_hit && n < 100) begin
            @(negedge clk_in);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bvalid && s_axi_bready;
            if (b_hit) r = s_axi_bresp;
            @(posedge clk_in);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            if (b_hit) s_axi_bready <= 1'b0;
            n++;
        end
        if (!b_hit) errors++;
    endtask

    // one read; data and response sampled mid-cycle, before the handshake edge
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hit, r_hit;
        int n;
        n = 0;
        r_hit = 1'b0;
        d = 32'hFFFFFFFF;
        r = 2'h3;
        @(posedge clk_in);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        while (!r_hit && n < 100) begin
            @(negedge clk_in);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rvalid && s_axi_rready;
            if (r_hit) d = s_axi_rdata;
            if (r_hit) r = s_axi_rresp;
            @(posedge clk_in);
            if (ar_hit) s_axi_arvalid <= 1'b0;
            if (r_hit) s_axi_rready <= 1'b0;
            n++;
        end
        if (!r_hit) errors++;
    endtask

    // write, read back, let decode land
    task automatic wr_rd(input logic [11:0] a, input logic [7:0] v, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(a, {24'h0, v}, 4'hF, r);
        check(32'(r), 32'h0, "write resp");
        axi_rd(a, d, r);
        check(d, {24'h0, exp}, "readback");
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    // reset contents and their decoded meaning
    task automatic test_reset_values();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(12'h038, d, r);
        check(d, 32'hE8, "tx dev reset");
        axi_rd(12'h03C, d, r);
        check(d, 32'h9C, "afc reset");
        axi_rd(12'h040, d, r);
        check(d, 32'h00, "filter reset");
        @(negedge clk_in);
        check(32'(cfg_out.gauss_shaping), 32'h1, "shaping");
        check(32'({cfg_out.tx_dev_exponent, cfg_out.tx_dev_mantissa}), 32'h68, "tx fields");
        check(32'({cfg_out.afc_enable, cfg_out.afc_avg_pairs}), 32'hA, "afc avg");
        check(32'({cfg_out.rx_dev_exponent, cfg_out.rx_dev_mantissa}), 32'h1C, "rx fields");
        check(32'(cfg_out.decim_divisor), 32'h1, "divisor");
        check(32'(chan_bw_out), 32'hC00, "bandwidth");
    endtask

    // tx deviation fields in both bands, mantissa zero gives on-off keying
    task automatic test_tx_dev();
        logic [7:0] vals [3] = '{8'h00, 8'h7F, 8'hBA};
        logic [5:0] ofs, sh;
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_in);
            upper_band_in <= b[0];
            repeat (4) @(posedge clk_in);
            ofs = b[0] ? 6'h0F : 6'h10;
            for (int i = 0; i < 3; i++) begin
                wr_rd(12'h038, vals[i], vals[i]);
                check(32'(cfg_out.gauss_shaping), 32'(vals[i][7]), "shaping");
                check(32'(cfg_out.tx_dev_exponent), 32'(vals[i][6:4]), "tx exp");
                check(32'(cfg_out.tx_dev_mantissa), 32'(vals[i][3:0]), "tx mant");
                check(32'(cfg_out.on_off_keying), 32'(vals[i][3:0] == 4'h0), "on-off keying");
                // exponent minus band offset, kept at six bits
                sh = {3'h0, vals[i][6:4]} - ofs;
                check(32'(cfg_out.tx_dev_shift), 32'(sh), "tx shift");
            end
        end
    endtask

    // every settling code and the receive deviation fields
    task automatic test_afc();
        logic [7:0] v;
        // the loop ends on the slowest settling code, which then stays set
        for (int c = 0; c < 4; c++) begin
            v = {c[1:0], 2'h2, 4'h9};
            wr_rd(12'h03C, v, v);
            check(32'(cfg_out.afc_enable), 32'(c != 0), "afc enable");
            check(32'(cfg_out.afc_avg_pairs), (c == 0) ? 32'h0 : 32'h1 << (c - 1), "avg pairs");
            check(32'({cfg_out.rx_dev_exponent, cfg_out.rx_dev_mantissa}), 32'h29, "rx fields");
        end
    endtask

    // every divisor code; reserved bits written as ones
    task automatic test_filter();
        logic [7:0] v;
        int dv;
        for (int c = 0; c < 8; c++) begin
            v = {c[0], c[1:0], 2'h3, c[2:0]};
            dv = (c == 7) ? 8 : c + 1;
            wr_rd(12'h040, v, v & 8'hE7);
            check(32'(cfg_out.filter_bypass), 32'(c[0]), "bypass");
            check(32'(cfg_out.decimator_input_shift), 32'(c[1:0]), "decimator_input_shift");
            check(32'(cfg_out.decim_divisor), 32'(dv), "divisor");
            check(32'(chan_bw_out), 32'(3072 / dv), "bandwidth");
        end
    endtask

    // unmapped places and a write with lane 0 disabled
    task automatic test_bus_errors();
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(12'h044, 32'hFF, 4'hF, r);
        check(32'(r), 32'h2, "unmapped write resp");
        axi_rd(12'h034, d, r);
        check({d[29:0], r}, 32'h2, "unmapped read");
        axi_wr(12'h038, 32'h11, 4'hE, r);
        axi_rd(12'h038, d, r);
        check(d, 32'hBA, "lane 0 off keeps value");
    endtask

    // watchdog sized well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        complete_run();
    end

    // main sequence, second reset in mid-run
    initial begin
        do_reset();
        test_reset_values();
        test_tx_dev();
        test_afc();
        test_filter();
        test_bus_errors();
        do_reset();
        repeat (2) @(posedge clk_in);
        test_reset_values();
        complete_run();
    end
endmodule // mdf_bank_tb
